// >>> rtl/mic_pkg.sv
// constants and types shared by the interrupt controller files
package mic_pkg;
  // =========================================================
  // register map: word indices, the byte address is four times the index
  localparam logic [11:0] OPTION_CONTROL_ADDR = 12'h081;
  localparam logic [11:0] IRQ_CONTROL_ADDR = 12'h00b;
  localparam logic [11:0] PERIPH_FLAGS_A_ADDR = 12'h00c;
  localparam logic [11:0] PERIPH_FLAGS_B_ADDR = 12'h00d;
  localparam logic [11:0] PERIPH_ENABLES_A_ADDR = 12'h08c;
  localparam logic [11:0] PERIPH_ENABLES_B_ADDR = 12'h08d;
  localparam logic [11:0] CORE_STATUS_ADDR = 12'h010;
  // =========================================================
  // irq control field positions, plus the edge select bit of the option control register
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PGE_BIT = 6;
  localparam int TIMER_EN_BIT = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int TIMER_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;
  localparam int EDGE_SEL_BIT = 6;
  // =========================================================
  // reset values
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [7:0] OPTION_CONTROL_RST = 8'hff;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  // =========================================================
  // vector and timing
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam int EXT_SYNC_STAGES = 2;
  // =========================================================
  // sequencer states
  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_SLEEP,
    MIC_ENTRY
  } mic_state_type;
endpackage

// >>> rtl/mic_edge_detect.sv
// edge detector for the external interrupt pin and the port-b change group
`timescale 1ns/1ps
module mic_edge_detect #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] sig_in, // sampled inputs
  output logic [WIDTH-1:0] rise, // rising edge pulse
  output logic [WIDTH-1:0] fall // falling edge pulse
);
  logic [WIDTH-1:0] prev_r;
  logic primed_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= sig_in;
      primed_r <= 1'b1;
    end
  end

  // no edge reported before the first sample after reset
  assign rise = primed_r ? (sig_in & ~prev_r) : '0;
  assign fall = primed_r ? (~sig_in & prev_r) : '0;
endmodule

// >>> rtl/mic_apb_slave.sv
// apb decode for the interrupt controller register file
`timescale 1ns/1ps
module mic_apb_slave (
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  output logic wr_stb, // write takes effect this edge
  output logic rd_stb, // read data taken this edge
  output logic [2:0] reg_sel, // decoded register index
  output logic hit // address is mapped
);
  logic [11:0] word_idx;

  // one aligned word per register, decoded by word index
  assign word_idx = {2'b00, paddr[11:2]};

  always_comb begin
    hit = (paddr[1:0] == 2'b00);
    reg_sel = 3'd0;
    case (word_idx)
      mic_pkg::IRQ_CONTROL_ADDR: reg_sel = 3'd0;
      mic_pkg::OPTION_CONTROL_ADDR: reg_sel = 3'd1;
      mic_pkg::PERIPH_FLAGS_A_ADDR: reg_sel = 3'd2;
      mic_pkg::PERIPH_FLAGS_B_ADDR: reg_sel = 3'd3;
      mic_pkg::PERIPH_ENABLES_A_ADDR: reg_sel = 3'd4;
      mic_pkg::PERIPH_ENABLES_B_ADDR: reg_sel = 3'd5;
      mic_pkg::CORE_STATUS_ADDR: reg_sel = 3'd6;
      default: hit = 1'b0;
    endcase
  end
  assign wr_stb = psel & penable & pwrite & hit;
  assign rd_stb = psel & penable & ~pwrite;
endmodule

// >>> rtl/mic_irq_ctrl.sv
// interrupt controller: flags, enables, vectoring, sleep wake-up
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module mic_irq_ctrl #(
  parameter int PERIPH_A_N = 8,
  parameter int PERIPH_B_N = 3
) (
  input wire logic clk, // instruction clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_irq_pin, // external interrupt pin
  input wire logic [3:0] port_b_pins, // upper port b pins
  input wire logic basic_timer_wrap, // timer rolled from ff to 00
  input wire logic [PERIPH_A_N-1:0] periph_evt_a, // peripheral events, group a
  input wire logic [PERIPH_B_N-1:0] periph_evt_b, // peripheral events, group b
  input wire logic [12:0] core_pc_next, // return address from core
  input wire logic instr_boundary, // core finishes an instruction
  input wire logic sleep_instr, // sleep instruction executing
  input wire logic return_from_irq_instr, // return instruction executing
  output logic irq_take, // pulse: core must branch to vector
  output logic [12:0] vector_addr, // address loaded into pc
  output logic stack_push, // pulse: push return address
  output logic [12:0] stack_data, // return address to push
  output logic core_sleeping, // core halted in sleep
  output logic wake_pulse, // pulse: leave sleep
  output logic power_down_n // power-down status, low after sleep
);
  logic [7:0] irq_control_r;
  logic [7:0] option_control_r;
  logic [PERIPH_A_N-1:0] flags_a_r, en_a_r;
  logic [PERIPH_B_N-1:0] flags_b_r, en_b_r;
  mic_pkg::mic_state_type state_r;
  logic ext_s1_r, ext_s2_r;
  logic [3:0] port_s1_r, port_s2_r;
  logic ext_rise, ext_fall, ext_edge;
  logic [3:0] port_rise, port_fall;
  logic wr_stb, hit;
  logic [2:0] reg_sel;
  logic [7:0] wbyte;
  logic periph_req, core_req, any_req;
  logic gie_set, gie_clr;
  logic take_now;
  logic wr_irq, wr_opt, wr_flags_a, wr_flags_b;
  logic wr_en_a, wr_en_b, wr_status;
  logic [7:0] irq_control_nxt;
  logic [PERIPH_A_N-1:0] flags_a_nxt;
  logic [PERIPH_B_N-1:0] flags_b_nxt;
  mic_pkg::mic_state_type state_nxt;

  // register select codes, in the order of the bus decode
  localparam logic [2:0] SEL_IRQ = 3'd0;
  localparam logic [2:0] SEL_OPT = 3'd1;
  localparam logic [2:0] SEL_FLAGS_A = 3'd2;
  localparam logic [2:0] SEL_FLAGS_B = 3'd3;
  localparam logic [2:0] SEL_EN_A = 3'd4;
  localparam logic [2:0] SEL_EN_B = 3'd5;
  localparam logic [2:0] SEL_STATUS = 3'd6;

  // =========================================================
  // parameter checks
  if (PERIPH_A_N < 1 || PERIPH_A_N > 8 || PERIPH_B_N < 1 || PERIPH_B_N > 8) begin : g_bad_width
    $error("peripheral group width must be 1..8");
  end
  if (PERIPH_A_N + PERIPH_B_N + 3 > 14) begin : g_too_many
    $error("more than fourteen sources");
  end

  // =========================================================
  // bus decode
  mic_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_stb(wr_stb),
    .rd_stb(),
    .reg_sel(reg_sel),
    .hit(hit)
  );
  assign wbyte = pwdata[7:0];

  // one write strobe per register
  function automatic logic reg_wr(input logic stb, input logic [2:0] sel,
    input logic [2:0] idx);
    return stb && (sel == idx);
  endfunction
  assign wr_irq = reg_wr(wr_stb, reg_sel, SEL_IRQ);
  assign wr_opt = reg_wr(wr_stb, reg_sel, SEL_OPT);
  assign wr_flags_a = reg_wr(wr_stb, reg_sel, SEL_FLAGS_A);
  assign wr_flags_b = reg_wr(wr_stb, reg_sel, SEL_FLAGS_B);
  assign wr_en_a = reg_wr(wr_stb, reg_sel, SEL_EN_A);
  assign wr_en_b = reg_wr(wr_stb, reg_sel, SEL_EN_B);
  assign wr_status = reg_wr(wr_stb, reg_sel, SEL_STATUS);

  function automatic logic [7:0] pad8(input logic [7:0] v);
    pad8 = v;
  endfunction

  // =========================================================
  // input synchronisers and edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      port_s1_r <= 4'h0;
      port_s2_r <= 4'h0;
    end else begin
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      port_s1_r <= port_b_pins;
      port_s2_r <= port_s1_r;
    end
  end

  mic_edge_detect #(.WIDTH(5)) u_edge (
    .clk(clk),
    .nrst(nrst),
    .sig_in({port_s2_r, ext_s2_r}),
    .rise({port_rise, ext_rise}),
    .fall({port_fall, ext_fall})
  );

  assign ext_edge = option_control_r[mic_pkg::EDGE_SEL_BIT] ? ext_rise : ext_fall;

  // =========================================================
  // request logic, one shared vector
  assign periph_req = (|(flags_a_r & en_a_r)) | (|(flags_b_r & en_b_r));
  assign core_req = (irq_control_r[mic_pkg::EXT_FLAG_BIT] & irq_control_r[mic_pkg::EXT_EN_BIT])
    | (irq_control_r[mic_pkg::TIMER_FLAG_BIT] & irq_control_r[mic_pkg::TIMER_EN_BIT])
    | (irq_control_r[mic_pkg::PORT_FLAG_BIT] & irq_control_r[mic_pkg::PORT_EN_BIT]);
  assign any_req = core_req | (periph_req & irq_control_r[mic_pkg::PGE_BIT]);

  // =========================================================
  // sequencer: run, sleep, entry
  assign take_now = (state_r == mic_pkg::MIC_RUN) && instr_boundary && any_req
    && irq_control_r[mic_pkg::GLOBAL_EN_BIT];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mic_pkg::MIC_RUN: begin
        if (take_now) begin
          state_nxt = mic_pkg::MIC_ENTRY;
        end else if (sleep_instr && !any_req) begin
          state_nxt = mic_pkg::MIC_SLEEP;
        end
      end
      mic_pkg::MIC_SLEEP: begin
        // wake on any enabled request; the vector follows only if enabled
        if (any_req) state_nxt = mic_pkg::MIC_RUN;
      end
      mic_pkg::MIC_ENTRY: state_nxt = mic_pkg::MIC_RUN;
      default: state_nxt = mic_pkg::MIC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= mic_pkg::MIC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // entry outputs: only the pc is saved
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_take <= 1'b0;
      stack_push <= 1'b0;
      stack_data <= 13'h0000;
      vector_addr <= mic_pkg::IRQ_VECTOR;
    end else begin
      irq_take <= take_now;
      stack_push <= take_now;
      if (take_now) stack_data <= core_pc_next;
      vector_addr <= mic_pkg::IRQ_VECTOR;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_sleeping <= 1'b0;
      wake_pulse <= 1'b0;
      power_down_n <= 1'b1;
    end else begin
      core_sleeping <= (state_r == mic_pkg::MIC_RUN) ? (sleep_instr && !any_req && !take_now)
        : (state_r == mic_pkg::MIC_SLEEP) && !any_req;
      wake_pulse <= (state_r == mic_pkg::MIC_SLEEP) && any_req;
      if (state_r == mic_pkg::MIC_RUN && sleep_instr && !any_req && !take_now)
        power_down_n <= 1'b0;
      else if (wr_status) power_down_n <= wbyte[0];
    end
  end

  // =========================================================
  // irq control register: flags set win over software clear
  assign gie_clr = take_now;
  assign gie_set = return_from_irq_instr;

  always_comb begin
    irq_control_nxt = irq_control_r;
    if (wr_irq) irq_control_nxt = wbyte;
    if (gie_set) irq_control_nxt[mic_pkg::GLOBAL_EN_BIT] = 1'b1;
    if (gie_clr) irq_control_nxt[mic_pkg::GLOBAL_EN_BIT] = 1'b0;
    if (ext_edge) irq_control_nxt[mic_pkg::EXT_FLAG_BIT] = 1'b1;
    if (basic_timer_wrap) irq_control_nxt[mic_pkg::TIMER_FLAG_BIT] = 1'b1;
    if (|(port_rise | port_fall)) irq_control_nxt[mic_pkg::PORT_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_control_r <= mic_pkg::IRQ_CONTROL_RST;
    end else begin
      irq_control_r <= irq_control_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      option_control_r <= mic_pkg::OPTION_CONTROL_RST;
    end else if (wr_opt) begin
      option_control_r <= wbyte;
    end
  end

  // peripheral flags sticky, set wins over clear
  always_comb begin
    flags_a_nxt = wr_flags_a ? wbyte[PERIPH_A_N-1:0] : flags_a_r;
    flags_a_nxt = flags_a_nxt | periph_evt_a;
    flags_b_nxt = wr_flags_b ? wbyte[PERIPH_B_N-1:0] : flags_b_r;
    flags_b_nxt = flags_b_nxt | periph_evt_b;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_a_r <= '0;
      flags_b_r <= '0;
    end else begin
      flags_a_r <= flags_a_nxt;
      flags_b_r <= flags_b_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_a_r <= '0;
      en_b_r <= '0;
    end else begin
      if (wr_en_a) en_a_r <= wbyte[PERIPH_A_N-1:0];
      if (wr_en_b) en_b_r <= wbyte[PERIPH_B_N-1:0];
    end
  end

  // =========================================================
  // apb answer, zero wait states
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && hit) begin
        case (reg_sel)
          SEL_IRQ: prdata <= {24'h0, pad8(irq_control_r)};
          SEL_OPT: prdata <= {24'h0, pad8(option_control_r)};
          SEL_FLAGS_A: prdata <= {24'h0, pad8(8'(flags_a_r))};
          SEL_FLAGS_B: prdata <= {24'h0, pad8(8'(flags_b_r))};
          SEL_EN_A: prdata <= {24'h0, pad8(8'(en_a_r))};
          SEL_EN_B: prdata <= {24'h0, pad8(8'(en_b_r))};
          SEL_STATUS: prdata <= {24'h0, 6'h00, core_sleeping, power_down_n};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> verif/mic_irq_chk.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
module mic_irq_chk (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic instr_boundary, // instruction end
  input wire logic sleep_instr, // sleep executing
  input wire logic irq_take, // branch to vector
  input wire logic [12:0] vector_addr, // vector
  input wire logic stack_push, // push strobe
  input wire logic core_sleeping, // core halted
  input wire logic wake_pulse, // leave sleep
  input wire logic power_down_n // power-down status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // =====================================
  // sequences
  sequence s_access; psel && penable; endsequence
  sequence s_entry; irq_take && stack_push; endsequence
  // =====================================
  // assertions
  chk_apb_ready: assert property (s_access |-> pready)
    else $error("access without ready");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access bad answer");
  chk_take_push: assert property (irq_take |-> s_entry)
    else $error("entry without push");
  chk_vec_fixed: assert property (s_entry |-> vector_addr == 13'h0004)
    else $error("wrong vector");
  chk_take_bound: assert property (irq_take |-> $past(instr_boundary))
    else $error("entry off boundary");
  chk_take_once: assert property (s_entry |=> !irq_take)
    else $error("entry repeated");
  chk_sleep_cause: assert property ($rose(core_sleeping) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  chk_pd_sleep: assert property (core_sleeping |-> !power_down_n)
    else $error("power-down flag high in sleep");
  chk_wake_leave: assert property (wake_pulse |=> !core_sleeping)
    else $error("still asleep after wake");
  chk_sleep_take: assert property (core_sleeping |-> !irq_take)
    else $error("entry while asleep");
endmodule

bind mic_irq_ctrl mic_irq_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
  .sleep_instr(sleep_instr), .irq_take(irq_take), .vector_addr(vector_addr),
  .stack_push(stack_push), .core_sleeping(core_sleeping), .wake_pulse(wake_pulse),
  .power_down_n(power_down_n));

// >>> verif/mic_core_model.sv
// behavioural core: program counter, return stack, sequencing
`timescale 1ns/1ps
module mic_core_model (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic irq_take, // branch to vector
  input wire logic [12:0] vector_addr, // vector
  input wire logic stack_push, // push strobe
  input wire logic [12:0] stack_data, // pushed address
  input wire logic core_sleeping, // halted
  input wire logic do_sleep, // bench asks sleep
  input wire logic do_return, // bench asks return
  output logic instr_boundary, // instruction end
  output logic sleep_instr, // sleep executing
  output logic return_from_irq_instr, // return executing
  output logic [12:0] core_pc_next, // return address
  output logic [12:0] pc_r, // program counter
  output logic [3:0] depth_r // stack depth
);
  logic [12:0] stack_r [0:7];
  assign instr_boundary = nrst && !core_sleeping;
  assign sleep_instr = do_sleep;
  assign return_from_irq_instr = do_return;
  assign core_pc_next = pc_r + 13'h0001;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= 13'h0000;
      depth_r <= 4'h0;
    end else if (irq_take) begin
      pc_r <= vector_addr;
    end else if (do_return && depth_r != 4'h0) begin
      pc_r <= stack_r[depth_r[2:0] - 3'h1];
      depth_r <= depth_r - 4'h1;
    end else if (instr_boundary) begin
      pc_r <= core_pc_next;
    end
    if (nrst && stack_push) begin
      stack_r[depth_r[2:0]] <= stack_data; // only the pc is kept
      depth_r <= depth_r + 4'h1;
    end
  end
endmodule

// >>> verif/tb_mcu_interrupt_controller.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_mcu_interrupt_controller;
  logic clk, nrst, psel, penable, pwrite, ext_irq_pin, basic_timer_wrap, do_sleep, do_return;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] port_b_pins, depth;
  logic [7:0] evt_a;
  logic [2:0] evt_b;
  logic [12:0] pc_next, vec, sdata, pc;
  logic pready, pslverr, err, ib, si, ri, take, push, slp, wake, pdn, seen;
  int failures, checked;
  mic_irq_ctrl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins), .basic_timer_wrap(basic_timer_wrap),
    .periph_evt_a(evt_a), .periph_evt_b(evt_b), .core_pc_next(pc_next),
    .instr_boundary(ib), .sleep_instr(si), .return_from_irq_instr(ri), .irq_take(take),
    .vector_addr(vec), .stack_push(push), .stack_data(sdata), .core_sleeping(slp),
    .wake_pulse(wake), .power_down_n(pdn));
  mic_core_model core (.clk(clk), .nrst(nrst), .irq_take(take), .vector_addr(vec),
    .stack_push(push), .stack_data(sdata), .core_sleeping(slp), .do_sleep(do_sleep),
    .do_return(do_return), .instr_boundary(ib), .sleep_instr(si), .return_from_irq_instr(ri),
    .core_pc_next(pc_next), .pc_r(pc), .depth_r(depth));
  // =====================================
  // helpers
  task end_of_test;
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cmp_bit(input logic g, input logic e);
    cmp_reg({31'h0, g}, {31'h0, e});
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a[9:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 8);
    if (pready !== 1'b1) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task watch(input int n, input bit use_wake, input bit must);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge clk);
      seen = use_wake ? (wake === 1'b1) : (take === 1'b1);
    end
    if (must && !seen) begin
      failures++;
      end_of_test();
    end
  endtask
  task pulse_core(input bit ret);
    @(posedge clk);
    if (ret) do_return <= 1'b1;
    else do_sleep <= 1'b1;
    @(posedge clk);
    do_return <= 1'b0;
    do_sleep <= 1'b0;
  endtask
  // =====================================
  // scenarios
  task t_reset;
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h0);
    apb(0, mic_pkg::OPTION_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'hff);
    apb(1, 12'h3f0, 8'h55); cmp_bit(err, 1'b1);
  endtask
  task t_ext;
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h90);
    @(posedge clk) ext_irq_pin <= 1'b1;
    watch(6, 0, 1);
    @(negedge clk); cmp_reg({19'h0, pc}, 32'h4);
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h12);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h10);
    pulse_core(1);
    @(posedge clk) ext_irq_pin <= 1'b0;
    watch(6, 0, 0); cmp_bit(seen, 1'b0);
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h90);
    cmp_reg({28'h0, depth}, 32'h0);
  endtask
  task t_timer;
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h20);
    @(posedge clk) basic_timer_wrap <= 1'b1;
    @(posedge clk) basic_timer_wrap <= 1'b0;
    watch(6, 0, 0); cmp_bit(seen, 1'b0);
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h24);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'ha4);
    watch(6, 0, 1);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h00);
  endtask
  task t_periph;
    apb(1, mic_pkg::PERIPH_ENABLES_A_ADDR, 8'h01);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h80);
    @(posedge clk) evt_a <= 8'h01;
    @(posedge clk) evt_a <= 8'h00;
    watch(6, 0, 0); cmp_bit(seen, 1'b0);
    apb(0, mic_pkg::PERIPH_FLAGS_A_ADDR, 8'h00); cmp_reg(rd, 32'h1);
    @(posedge clk) evt_b <= 3'h4;
    @(posedge clk) evt_b <= 3'h0;
    apb(0, mic_pkg::PERIPH_FLAGS_B_ADDR, 8'h00); cmp_reg(rd, 32'h4);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'hc0);
    watch(6, 0, 1);
    apb(1, mic_pkg::PERIPH_FLAGS_A_ADDR, 8'h00);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h08);
    @(posedge clk) port_b_pins <= 4'h8;
    repeat (4) @(posedge clk);
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h09);
  endtask
  task t_sleep;
    apb(1, mic_pkg::OPTION_CONTROL_ADDR, 8'hbf);
    apb(1, mic_pkg::IRQ_CONTROL_ADDR, 8'h10);
    pulse_core(0);
    @(negedge clk); cmp_bit(slp, 1'b1);
    apb(0, mic_pkg::CORE_STATUS_ADDR, 8'h00); cmp_reg(rd, 32'h2);
    @(posedge clk) ext_irq_pin <= 1'b1;
    watch(6, 1, 0); cmp_bit(seen, 1'b0);
    @(posedge clk) ext_irq_pin <= 1'b0;
    watch(8, 1, 1);
    watch(6, 0, 0); cmp_bit(seen, 1'b0);
    cmp_bit(pdn, 1'b0);
    apb(0, mic_pkg::CORE_STATUS_ADDR, 8'h00); cmp_reg(rd, 32'h0);
    apb(0, mic_pkg::IRQ_CONTROL_ADDR, 8'h00); cmp_reg(rd, 32'h12);
  endtask
  // =====================================
  // clock, reset, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, ext_irq_pin, basic_timer_wrap, do_sleep, do_return} = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    port_b_pins = 4'h0;
    evt_a = 8'h0;
    evt_b = 3'h0;
    failures = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ext();
    t_timer();
    t_periph();
    t_sleep();
    end_of_test();
  end
endmodule
